// [common/drive_profile_map.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef DRIVE_PROFILE_MAP_SVH
`define DRIVE_PROFILE_MAP_SVH

// Register addresses (word addressed plain port)
`define ADDR_PROF_LAST  8'h17
`define ADDR_CONFIG     8'h18
`define ADDR_SOFT       8'h19
`define ADDR_STATUS     8'h1A
`define ADDR_DEMAND     8'h1B
`define ADDR_PIDX       4:2
`define ADDR_WIDX       1:0

// Profile bank shape and profile numbers
`define PROF_COUNT      6
`define PROF_WORDS      4
`define PROF_NONDRIVE   3'h0
`define PROF_FIRST      3'h1
`define PROF_ATTEND     3'h6

// Profile word indexes and fields
`define W_SPEED         2'h0
`define W_TURNACC       2'h1
`define W_RATES         2'h2
`define W_SOURCE        2'h3
`define F_LO            7:0
`define F_ML            15:8
`define F_MH            23:16
`define F_HI            31:24
`define F_SRC           2:0

// Profile reset words: speeds, turn speeds/fwd rates, rev/turn rates, source
`define PROF_W0_RST     32'h0546_0564
`define PROF_W1_RST     32'h3C28_0532
`define PROF_W2_RST     32'h3C28_4623
`define PROF_W3_RST     32'h0000_0000

// Config register fields and reset value
`define CFG_SDAMP       7:0
`define CFG_TDAMP       15:8
`define CFG_RATIO       23:16
`define CFG_WRAP        24
`define CFG_ALLOW0      25
`define CFG_SOFTEN      26
`define CFG_MAXP        30:28
`define CFG_RST         32'h5114_2828
`define SOFT_TIME       9:0
`define SOFT_RST        10'h000

// Status fields
`define STAT_ACTIVE     2:0
`define STAT_ATTEND     3
`define STAT_INHIBIT    4

// Demand scaling: percent in Q8, damping zone of 1/16 percent per unit of setting
`define PCT_FULL        100
`define Q_SCALE         256
`define DAMP_UNIT       16

// Control tick
`define TICK_PERIOD_US  1000
`define CLK_MHZ         50

`endif

// [common/drive_profile_pkg.sv]
// Types shared by the speed ramp design
`default_nettype none
package drive_profile_pkg;

   typedef enum logic [0:0] {
      SEL_USER   = 1'b0,
      SEL_ATTEND = 1'b1
   } selMode_t;

   typedef logic [5:0][3:0][31:0] profBank_t;

   typedef struct packed {
      profBank_t               prof;
      logic [31:0]             cfg;
      logic [9:0]              softTime;
      logic [15:0]             tickCnt;
      logic                    tick;
      logic [7:0]              pinA;
      logic [7:0]              pinB;
      logic [7:0]              pinC;
      selMode_t                mode;
      logic [2:0]              active;
      logic [2:0]              saved;
      logic [31:0]             rdata;
      logic signed [15:0]      fwdOut;
      logic signed [15:0]      turnOut;
      logic                    inhibit;
   } topState_t;

   typedef struct packed {
      logic signed [15:0]      demand;
      logic [9:0]              softCnt;
   } rampState_t;

endpackage
`default_nettype wire

// [common/ramp_if.sv]
// Carrier between the profile logic and one ramp axis
`timescale 1ns/10ps
`default_nettype none
interface ramp_if;
   logic                    tick;
   logic signed [15:0]      target;
   logic [7:0]              accRate;
   logic [7:0]              decRate;
   logic [7:0]              endRatio;
   logic [15:0]             dampZone;
   logic                    softEn;
   logic [9:0]              softTime;
   logic signed [15:0]      demand;

   modport ctrl (output tick, target, accRate, decRate, endRatio,
                 dampZone, softEn, softTime, input demand);
   modport axis (input tick, target, accRate, decRate, endRatio,
                 dampZone, softEn, softTime, output demand);
endinterface
`default_nettype wire

// [rtl/ramp_axis.sv]
// One demand axis: rate limited ramp with end damping and soft start
`timescale 1ns/10ps
`default_nettype none
`include "drive_profile_map.svh"
module ramp_axis (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // Parameters in, demand out
   ramp_if.axis      link
);

   drive_profile_pkg::rampState_t cur;
   drive_profile_pkg::rampState_t next_cur;

   // Step size from rate, damping and soft start, applied once per tick
   always_comb begin
      int err;
      int mag;
      int base;
      int step;
      int damped;
      int floorStep;
      int dem;
      logic away;
      next_cur = cur;
      dem = int'(cur.demand);
      err = int'(link.target) - dem;
      mag = (err < 0) ? -err : err;
      damped = 0;
      floorStep = 0;
      away = (err > 0 && dem >= 0) || (err < 0 && dem <= 0);
      base = away ? int'(link.accRate) : int'(link.decRate);
      step = base;
      if (link.dampZone != 16'h0000 && mag < int'(link.dampZone)) begin
         damped = base * mag / int'(link.dampZone);
         floorStep = base * int'(link.endRatio) / `PCT_FULL;
         step = (damped > floorStep) ? damped : floorStep;
      end
      if (link.softEn && away && link.softTime != 10'h000 &&
          cur.softCnt < link.softTime) begin
         step = step * (int'(cur.softCnt) + 1) / int'(link.softTime);
      end
      // Never stall short of the target
      if (step < 1) begin
         step = 1;
      end
      if (link.tick) begin
         if (mag <= step) begin
            next_cur.demand = link.target;
         end else if (err > 0) begin
            next_cur.demand = 16'(dem + step);
         end else begin
            next_cur.demand = 16'(dem - step);
         end
         if (dem == 0 && link.target == 16'sh0000) begin
            next_cur.softCnt = 10'h000;
         end else if (away && cur.softCnt < link.softTime) begin
            next_cur.softCnt = cur.softCnt + 10'h001;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.demand = cur.demand;

endmodule // ramp_axis
`default_nettype wire

// [rtl/drive_profile_speed_ramp.sv]
// Drive profile bank, profile selection and speed demand shaping
`timescale 1ns/10ps
`default_nettype none
`include "drive_profile_map.svh"
module drive_profile_speed_ramp #(
   parameter int TICK_CYCLES = `TICK_PERIOD_US * `CLK_MHZ
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               resetn,
   // Register port
   input  wire logic [7:0]         regAddr,
   input  wire logic [31:0]        regWdata,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output var  logic [31:0]        regRdata,
   // Joystick and speed pot, same clock domain
   input  wire logic signed [7:0]  joyFwd,
   input  wire logic signed [7:0]  joyTurn,
   input  wire logic [6:0]         speedPot,
   // Profile selection pins
   input  wire logic               selUpPin,
   input  wire logic               selDownPin,
   input  wire logic               extProfValid,
   input  wire logic [2:0]         extProf,
   // Attendant unit pins
   input  wire logic               attendantPresent,
   input  wire logic               attendantModePin,
   // Demand to the motor power stage and status outputs
   output var  logic signed [15:0] fwdDemand,
   output var  logic signed [15:0] turnDemand,
   output var  logic [2:0]         activeProfile,
   output var  logic               driveInhibit,
   output var  logic               attendantActive
);

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam logic [127:0] PROF_RST =
      {`PROF_W3_RST, `PROF_W2_RST, `PROF_W1_RST, `PROF_W0_RST};
   localparam drive_profile_pkg::topState_t ST_RESET = '{
      prof:     {`PROF_COUNT{PROF_RST}},
      cfg:      `CFG_RST,
      softTime: `SOFT_RST,
      tickCnt:  16'h0000,
      tick:     1'b0,
      pinA:     8'h00,
      pinB:     8'h00,
      pinC:     8'h00,
      mode:     drive_profile_pkg::SEL_USER,
      active:   `PROF_FIRST,
      saved:    `PROF_FIRST,
      rdata:    32'h0000_0000,
      fwdOut:   16'sh0000,
      turnOut:  16'sh0000,
      inhibit:  1'b0
   };

   drive_profile_pkg::topState_t cur;
   drive_profile_pkg::topState_t next_cur;

   ramp_if fwdLink ();
   ramp_if turnLink ();

   // Target demand in Q8 percent of top speed from deflection and pot
   function automatic logic signed [15:0] targetOf(
      input logic signed [7:0] joy,
      input logic [7:0]        maxS,
      input logic [7:0]        minS,
      input logic [6:0]        pot
   );
      int span;
      int lim;
      span = (maxS > minS) ? int'(maxS) - int'(minS) : 0;
      lim = int'(minS) + span * int'(pot) / `PCT_FULL;
      return 16'(int'(joy) * lim * `Q_SCALE / `PCT_FULL);
   endfunction

   // Next profile when stepping up through the selection order
   function automatic logic [2:0] stepUp(
      input logic [2:0] act,
      input logic [2:0] maxP,
      input logic       wrap,
      input logic       allow0
   );
      logic [2:0] res;
      res = act;
      if (act == `PROF_NONDRIVE) begin
         res = `PROF_FIRST;
      end else if (act >= maxP) begin
         if (wrap) begin
            res = allow0 ? `PROF_NONDRIVE : `PROF_FIRST;
         end
      end else begin
         res = act + 3'h1;
      end
      return res;
   endfunction

   // Next profile when stepping down through the selection order
   function automatic logic [2:0] stepDown(
      input logic [2:0] act,
      input logic [2:0] maxP,
      input logic       wrap,
      input logic       allow0
   );
      logic [2:0] res;
      res = act;
      if (act == `PROF_NONDRIVE) begin
         if (wrap) begin
            res = maxP;
         end
      end else if (act == `PROF_FIRST) begin
         if (allow0) begin
            res = `PROF_NONDRIVE;
         end else if (wrap) begin
            res = maxP;
         end
      end else begin
         res = act - 3'h1;
      end
      return res;
   endfunction

   // Selection, register access, tick divider and pin synchronisers
   always_comb begin
      logic       upEv;
      logic       downEv;
      logic       extEv;
      logic       attend;
      logic       wrap;
      logic       allow0;
      logic [2:0] maxP;
      logic [2:0] extSel;
      next_cur = cur;
      // Two flip-flops before any logic looks at a pin
      next_cur.pinA = {extProf, extProfValid, attendantModePin,
                       attendantPresent, selDownPin, selUpPin};
      next_cur.pinB = cur.pinA;
      next_cur.pinC = cur.pinB;
      upEv   = cur.pinB[0] & ~cur.pinC[0];
      downEv = cur.pinB[1] & ~cur.pinC[1];
      extEv  = cur.pinB[4] & ~cur.pinC[4];
      extSel = cur.pinB[7:5];
      attend = cur.pinB[2] & cur.pinB[3];
      wrap   = cur.cfg[`CFG_WRAP];
      allow0 = cur.cfg[`CFG_ALLOW0];
      maxP   = cur.cfg[`CFG_MAXP];
      // Fixed control tick; one-cycle enable for both ramps
      next_cur.tick = (cur.tickCnt == TICK_LAST);
      next_cur.tickCnt = next_cur.tick ? 16'h0000 : cur.tickCnt + 16'h0001;

      unique case (cur.mode)
         drive_profile_pkg::SEL_USER: begin
            if (attend) begin
               next_cur.saved  = cur.active;
               next_cur.active = `PROF_ATTEND;
               next_cur.mode   = drive_profile_pkg::SEL_ATTEND;
            end else if (extEv && extSel >= `PROF_FIRST &&
                         extSel <= maxP) begin
               next_cur.active = extSel;
            end else if (upEv) begin
               next_cur.active = stepUp(cur.active, maxP, wrap, allow0);
            end else if (downEv) begin
               next_cur.active = stepDown(cur.active, maxP, wrap, allow0);
            end else if (cur.active == `PROF_NONDRIVE && !allow0) begin
               next_cur.active = `PROF_FIRST;
            end else if (cur.active > maxP) begin
               next_cur.active = maxP;
            end
         end
         drive_profile_pkg::SEL_ATTEND: begin
            // Selection inputs are ignored while the attendant drives
            if (!attend) begin
               next_cur.active = cur.saved;
               next_cur.mode   = drive_profile_pkg::SEL_USER;
            end
         end
      endcase
      next_cur.inhibit = (next_cur.active == `PROF_NONDRIVE);

      // Register writes; the profile bank is fully software programmable
      if (regWr) begin
         if (regAddr <= `ADDR_PROF_LAST) begin
            next_cur.prof[regAddr[`ADDR_PIDX]][regAddr[`ADDR_WIDX]] =
               regWdata;
         end else if (regAddr == `ADDR_CONFIG) begin
            next_cur.cfg = regWdata;
         end else if (regAddr == `ADDR_SOFT) begin
            next_cur.softTime = regWdata[`SOFT_TIME];
         end
      end

      // Read data stands only in the cycle after the strobe
      next_cur.rdata = 32'h0000_0000;
      if (regRd) begin
         if (regAddr <= `ADDR_PROF_LAST) begin
            next_cur.rdata =
               cur.prof[regAddr[`ADDR_PIDX]][regAddr[`ADDR_WIDX]];
         end else if (regAddr == `ADDR_CONFIG) begin
            next_cur.rdata = cur.cfg;
         end else if (regAddr == `ADDR_SOFT) begin
            next_cur.rdata[`SOFT_TIME] = cur.softTime;
         end else if (regAddr == `ADDR_STATUS) begin
            next_cur.rdata[`STAT_ACTIVE]  = cur.active;
            next_cur.rdata[`STAT_ATTEND]  =
               (cur.mode == drive_profile_pkg::SEL_ATTEND);
            next_cur.rdata[`STAT_INHIBIT] = cur.inhibit;
         end else if (regAddr == `ADDR_DEMAND) begin
            next_cur.rdata = {cur.turnOut, cur.fwdOut};
         end
      end

      // Outputs re-registered so every port leaves a flop
      next_cur.fwdOut  = fwdLink.demand;
      next_cur.turnOut = turnLink.demand;
   end

   // Active parameters for both ramp axes
   always_comb begin
      logic [2:0]  pIdx;
      logic [31:0] wSpeed;
      logic [31:0] wTurnAcc;
      logic [31:0] wRates;
      logic        useRev;
      pIdx = (cur.active == `PROF_NONDRIVE) ? 3'h0 : cur.active - 3'h1;
      wSpeed   = cur.prof[pIdx][`W_SPEED];
      wTurnAcc = cur.prof[pIdx][`W_TURNACC];
      wRates   = cur.prof[pIdx][`W_RATES];
      // Direction follows the moving demand, else the request
      useRev = (fwdLink.demand != 16'sh0000) ? fwdLink.demand[15] : joyFwd[7];

      fwdLink.tick  = cur.tick;
      turnLink.tick = cur.tick;
      if (cur.inhibit) begin
         fwdLink.target  = 16'sh0000;
         turnLink.target = 16'sh0000;
      end else begin
         fwdLink.target = joyFwd[7] ?
            targetOf(joyFwd, wSpeed[`F_MH], wSpeed[`F_HI], speedPot) :
            targetOf(joyFwd, wSpeed[`F_LO], wSpeed[`F_ML], speedPot);
         turnLink.target =
            targetOf(joyTurn, wTurnAcc[`F_LO], wTurnAcc[`F_ML], speedPot);
      end
      fwdLink.accRate  = useRev ? wRates[`F_LO] : wTurnAcc[`F_MH];
      fwdLink.decRate  = useRev ? wRates[`F_ML] : wTurnAcc[`F_HI];
      turnLink.accRate = wRates[`F_MH];
      turnLink.decRate = wRates[`F_HI];
      fwdLink.dampZone  = 16'(int'(cur.cfg[`CFG_SDAMP]) * `DAMP_UNIT);
      turnLink.dampZone = 16'(int'(cur.cfg[`CFG_TDAMP]) * `DAMP_UNIT);
      fwdLink.endRatio  = cur.cfg[`CFG_RATIO];
      turnLink.endRatio = cur.cfg[`CFG_RATIO];
      fwdLink.softEn    = cur.cfg[`CFG_SOFTEN];
      turnLink.softEn   = cur.cfg[`CFG_SOFTEN];
      fwdLink.softTime  = cur.softTime;
      turnLink.softTime = cur.softTime;
   end

   // Forward and reverse axis
   ramp_axis fwdRamp (
      .core_clk (core_clk),
      .resetn   (resetn),
      .link     (fwdLink.axis)
   );

   // Turning axis
   ramp_axis turnRamp (
      .core_clk (core_clk),
      .resetn   (resetn),
      .link     (turnLink.axis)
   );

   // State register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= ST_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from state flops
   assign regRdata        = cur.rdata;
   assign fwdDemand       = cur.fwdOut;
   assign turnDemand      = cur.turnOut;
   assign activeProfile   = cur.active;
   assign driveInhibit    = cur.inhibit;
   assign attendantActive = (cur.mode == drive_profile_pkg::SEL_ATTEND);

endmodule // drive_profile_speed_ramp
`default_nettype wire

// [testbench/drive_profile_speed_ramp_checker.sv]
// Port-level assertions for the speed ramp block
`timescale 1ns/10ps
`default_nettype none
module drive_profile_speed_ramp_checker #(
   parameter int TICK_CYCLES = 50000
) (
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               resetn,
   // Register port
   input wire logic [7:0]         regAddr,
   input wire logic               regRd,
   input wire logic [31:0]        regRdata,
   // Attendant pins
   input wire logic               attendantPresent,
   input wire logic               attendantModePin,
   // Demand and status outputs
   input wire logic signed [15:0] fwdDemand,
   input wire logic signed [15:0] turnDemand,
   input wire logic [2:0]         activeProfile,
   input wire logic               driveInhibit,
   input wire logic               attendantActive
);
   logic signed [15:0] prevFwd;
   logic signed [15:0] prevTurn;
   logic [15:0]        gapCnt;
   logic [2:0]         prevProf;
   logic               moved;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Any change of either demand output
   assign moved = (fwdDemand != prevFwd) || (turnDemand != prevTurn);

   // Gap counter saturates so a long idle never wraps into a false fire
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prevFwd  <= 16'sh0;
         prevTurn <= 16'sh0;
         gapCnt   <= 16'hFFFF;
         prevProf <= 3'h1;
      end else begin
         prevFwd  <= fwdDemand;
         prevTurn <= turnDemand;
         gapCnt   <= moved ? 16'h0 :
                     (gapCnt == 16'hFFFF ? gapCnt : gapCnt + 16'h1);
         prevProf <= attendantActive ? prevProf : activeProfile;
      end
   end

   a_read_idle: assert property (
      !$past(regRd) |-> regRdata == 32'h0) else $error("read data not idle");
   a_unmapped_read: assert property (
      $past(regRd) && $past(regAddr) > 8'h1B |-> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_inhibit_prof: assert property (
      driveInhibit == (activeProfile == 3'h0)) else $error("inhibit mismatch");
   a_attend_prof: assert property (
      attendantActive == (activeProfile == 3'h6))
      else $error("attendant mismatch");
   a_attend_entry: assert property (
      (attendantPresent && attendantModePin) [*8] |-> attendantActive)
      else $error("attendant not taken");
   a_attend_exit: assert property (
      (!attendantModePin) [*8] |-> !attendantActive)
      else $error("attendant kept");
   a_attend_restore: assert property (
      $fell(attendantActive) |-> activeProfile == prevProf)
      else $error("profile not restored");
   a_tick_spacing: assert property (
      moved |-> gapCnt >= TICK_CYCLES - 1) else $error("demand moved off tick");
   a_step_bound: assert property (
      moved |-> fwdDemand - prevFwd <= 255 && prevFwd - fwdDemand <= 255
         && turnDemand - prevTurn <= 255 && prevTurn - turnDemand <= 255)
      else $error("demand step too large");
   a_inhibit_hold: assert property (
      driveInhibit && $past(driveInhibit) && fwdDemand == 16'sh0
      && turnDemand == 16'sh0 |=> fwdDemand == 16'sh0 && turnDemand == 16'sh0)
      else $error("inhibited demand moved");
endmodule // drive_profile_speed_ramp_checker
`default_nettype wire

// [testbench/motor_stage_model.sv]
// Motor power stage stand-in that watches the demand it receives
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               resetn,
   // Demand from the ramp block
   input  wire logic signed [15:0] fwdDemand,
   // Largest forward demand seen
   output var  logic signed [15:0] peakFwd
);
   // demand read as Q8 percent of top speed
   // Pure sink: the stage never pushes back, so overshoot shows here
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         peakFwd <= 16'sh0;
      end else if (fwdDemand > peakFwd) begin
         peakFwd <= fwdDemand;
      end
   end
endmodule // motor_stage_model
`default_nettype wire

// [testbench/tb_drive_profile_speed_ramp.sv]
// Self-checking bench for the speed ramp block
`timescale 1ns/10ps
`default_nettype none
module tb_drive_profile_speed_ramp;
   localparam int T = 20;
   typedef struct packed { logic [7:0] addr; logic [31:0] exp; } row_t;
   logic               core_clk, resetn, regWr, regRd;
   logic [7:0]         regAddr;
   logic [31:0]        regWdata, regRdata;
   logic signed [7:0]  joyFwd, joyTurn;
   logic [6:0]         speedPot;
   logic               selUpPin, selDownPin, extProfValid;
   logic [2:0]         extProf, activeProfile;
   logic               attendantPresent, attendantModePin;
   logic signed [15:0] fwdDemand, turnDemand, peakFwd;
   logic               driveInhibit, attendantActive;
   int                 nFail, nTests, n, n0;
   row_t rows [8] = '{'{8'h00, 32'h0546_0564}, '{8'h05, 32'h3C28_0532},
      '{8'h16, 32'h3C28_4623}, '{8'h17, 32'h0}, '{8'h18, 32'h5114_2828},
      '{8'h19, 32'h0}, '{8'h1A, 32'h1}, '{8'h1C, 32'h0}};

   drive_profile_speed_ramp #(.TICK_CYCLES(T)) u_dut (.core_clk(core_clk),
      .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .joyFwd(joyFwd), .joyTurn(joyTurn),
      .speedPot(speedPot), .selUpPin(selUpPin), .selDownPin(selDownPin),
      .extProfValid(extProfValid), .extProf(extProf),
      .attendantPresent(attendantPresent), .attendantModePin(attendantModePin),
      .fwdDemand(fwdDemand), .turnDemand(turnDemand),
      .activeProfile(activeProfile), .driveInhibit(driveInhibit),
      .attendantActive(attendantActive));
   motor_stage_model u_motor (.core_clk(core_clk), .resetn(resetn),
      .fwdDemand(fwdDemand), .peakFwd(peakFwd));

   // Free-running system clock
   always #10 core_clk = ~core_clk;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         nFail++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // Cycle counts are bench integers, so a window check suffices
   task automatic chkIn(input string nm, input int lo, input int hi,
                        input int g);
      nTests++;
      if (g < lo || g > hi) begin
         nFail++;
         $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe edge
   task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd   <= 1'b0;
      #1 chk("regRdata", e, regRdata);
   endtask

   // Drive joystick, count cycles until both demands settle on target
   task automatic ramp(input logic signed [7:0] jf, input logic signed [7:0] jt,
                       input logic signed [15:0] tf, input logic signed [15:0] tt);
      @(posedge core_clk);
      joyFwd  <= jf;
      joyTurn <= jt;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (!(fwdDemand === tf && turnDemand === tt) && n < 12000);
      if (n >= 12000) begin
         chk("demand settle", 32'h1, 32'h0);
         summarize();
      end
   endtask

   // Pulse a selection input; the profile register follows within 8 cycles
   task automatic sel(input int which, input logic [2:0] ext,
                      input logic [2:0] e);
      @(posedge core_clk);
      extProf <= ext;
      @(posedge core_clk);
      case (which)
         0: selUpPin <= 1'b1;
         1: selDownPin <= 1'b1;
         default: extProfValid <= 1'b1;
      endcase
      repeat (8) @(posedge core_clk);
      #1 chk("activeProfile", {29'h0, e}, {29'h0, activeProfile});
      @(posedge core_clk);
      selUpPin     <= 1'b0;
      selDownPin   <= 1'b0;
      extProfValid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic att(input logic m, input logic [2:0] e);
      @(posedge core_clk);
      attendantPresent <= 1'b1;
      attendantModePin <= m;
      repeat (8) @(posedge core_clk);
      #1 chk("activeProfile", {29'h0, e}, {29'h0, activeProfile});
      chk("attendantActive", {31'h0, m}, {31'h0, attendantActive});
   endtask

   initial begin
      {core_clk, resetn, regWr, regRd, regAddr, regWdata} = '0;
      {joyFwd, joyTurn, selUpPin, selDownPin, extProfValid, extProf} = '0;
      {attendantPresent, attendantModePin, nFail, nTests} = '0;
      speedPot = 7'h64;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      // Reset values and an unmapped place, one row each
      foreach (rows[i]) chkReg(rows[i].addr, rows[i].exp);
      wr(8'h1A, 32'hFFFF_FFFF);
      wr(8'h20, 32'hFFFF_FFFF);
      chkReg(8'h1A, 32'h1);
      // Profile 5 speed word written and read back
      wr(8'h10, 32'h0A64_0A64);
      chkReg(8'h10, 32'h0A64_0A64);
      $display("test registers done");
      wr(8'h18, 32'h5114_0000);
      ramp(8'sd50, 8'sd0, 16'sd12800, 16'sd0);
      n0 = n;
      chkIn("accel cycles", 319 * T, 322 * T, n);
      ramp(8'sd0, 8'sd0, 16'sd0, 16'sd0);
      chkIn("decel cycles", 213 * T, 216 * T, n);
      ramp(-8'sd50, 8'sd50, -16'sd8960, 16'sd6400);
      chkIn("rev turn accel", 255 * T, 258 * T, n);
      ramp(8'sd0, 8'sd0, 16'sd0, 16'sd0);
      chkIn("rev turn decel", 127 * T, 130 * T, n);
      $display("test undamped ramps done");
      wr(8'h18, 32'h5114_2828);
      ramp(8'sd50, 8'sd0, 16'sd12800, 16'sd0);
      chkIn("damped cycles", n0 + 10 * T, 12000, n);
      chk("peakFwd", 32'h3200, {16'h0, peakFwd});
      ramp(8'sd0, 8'sd0, 16'sd0, 16'sd0);
      wr(8'h18, 32'h5164_2828);
      ramp(8'sd50, 8'sd0, 16'sd12800, 16'sd0);
      chkIn("full ratio", 319 * T, 322 * T, n);
      ramp(8'sd0, 8'sd0, 16'sd0, 16'sd0);
      wr(8'h19, 32'h64);
      wr(8'h18, 32'h5514_0000);
      ramp(8'sd50, 8'sd0, 16'sd12800, 16'sd0);
      chkIn("soft cycles", n0 + 20 * T, 12000, n);
      ramp(8'sd0, 8'sd0, 16'sd0, 16'sd0);
      $display("test damping done");
      wr(8'h18, 32'h5114_0000);
      sel(1, 3'h0, 3'h5);
      sel(0, 3'h0, 3'h1);
      sel(0, 3'h0, 3'h2);
      sel(2, 3'h4, 3'h4);
      sel(2, 3'h7, 3'h4);
      att(1'b1, 3'h6);
      sel(0, 3'h0, 3'h6);
      att(1'b0, 3'h4);
      sel(2, 3'h1, 3'h1);
      $display("test selection done");
      wr(8'h18, 32'h5314_0000);
      ramp(8'sd50, 8'sd0, 16'sd12800, 16'sd0);
      sel(1, 3'h0, 3'h0);
      chk("driveInhibit", 32'h1, {31'h0, driveInhibit});
      ramp(8'sd50, 8'sd0, 16'sd0, 16'sd0);
      chkIn("inhibit decel", 212 * T, 216 * T, n);
      sel(1, 3'h0, 3'h5);
      sel(0, 3'h0, 3'h0);
      sel(0, 3'h0, 3'h1);
      $display("test non-driving done");
      // Pot at zero limits demand to the profile minimum
      speedPot <= 7'h00;
      ramp(8'sd100, 8'sd0, 16'sd1280, 16'sd0);
      chkReg(8'h1B, 32'h0000_0500);
      $display("test speed pot done");
      // Second reset in mid-run restores defaults
      resetn <= 1'b0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      #1 chk("activeProfile", 32'h1, {29'h0, activeProfile});
      chk("fwdDemand", 32'h0, {16'h0, fwdDemand});
      chkReg(8'h18, 32'h5114_2828);
      $display("test reset done");
      summarize();
   end
endmodule // tb_drive_profile_speed_ramp

bind drive_profile_speed_ramp drive_profile_speed_ramp_checker #(
   .TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk(core_clk), .resetn(resetn),
   .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
   .attendantPresent(attendantPresent), .attendantModePin(attendantModePin),
   .fwdDemand(fwdDemand), .turnDemand(turnDemand),
   .activeProfile(activeProfile), .driveInhibit(driveInhibit),
   .attendantActive(attendantActive));
`default_nettype wire
